/* design/dcc_pkg.sv */
/*
  Constants for the device-control command decoder.
  Assumes a single 50 MHz system clock and a bus clock sampled as data.
*/
// How it works
// RULE_01 - mask 000: all seven address bits match
// RULE_02 - mask 011: address bits 6:3 match id
// RULE_03 - mask 111: broadcast, address field ignored
// RULE_04 - first data byte select picks starting byte
// RULE_05 - first byte select honoured only in generic
// RULE_06 - burst length places check byte after data
// RULE_07 - format bit: 0 generic, 1 register write
// RULE_08 - byte 0 bit 7 sets check enable
// RULE_09 - byte 0 bit 6 sets parity disable
// RULE_10 - byte 1 bit 3 clears all events
// RULE_11 - reserved generic data bits are ignored
// RULE_12 - no acknowledge after error plus repeated start
// RULE_13 - after reset, i2c mode, open-drain only
// RULE_14 - i3c mode switches drive by bus phase
// RULE_15 - open-drain for start header and acknowledges
// RULE_16 - push-pull for repeated start, codes, stop
// RULE_17 - push-pull for data, payload, check bytes
// RULE_18 - host appends check byte, header excluded
// RULE_19 - host omits unused second register byte
// RULE_20 - host usually broadcasts, may address targets
package dcc_pkg;
  // ---------------------------------------------------------------
  // bus framing
  // ---------------------------------------------------------------
  localparam logic [7:0] HDR_WRITE = 8'hfc; // 7'h7e with write bit
  localparam logic [7:0] CODE_DEVICE_CONTROL = 8'h62;
  localparam logic [3:0] ACK_BIT = 4'h8; // ninth bit of a byte
  localparam logic [2:0] MASK_UNICAST = 3'h0;
  localparam logic [2:0] MASK_MULTICAST = 3'h3;
  localparam logic [2:0] MASK_BROADCAST = 3'h7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DEF_MASK_LSB = 5;
  localparam int DEF_FIRST_LSB = 3;
  localparam int DEF_BURST_LSB = 1;
  localparam int DEF_FORMAT_BIT = 0;
  localparam int ADDR_ID_LSB = 3;
  localparam int B0_CHECK_EN_BIT = 7;
  localparam int B0_PARITY_DIS_BIT = 6;
  localparam int B1_CLEAR_BIT = 3;
  localparam logic [2:0] BYTE_CFG = 3'h0;
  localparam logic [2:0] BYTE_INT = 3'h1;
  localparam logic [2:0] BYTE_LIMIT = 3'h4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_CHECK_EN = 1'b0;
  localparam logic RST_PARITY_DIS = 1'b0;
  // ---------------------------------------------------------------
  // decoder states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DCC_IDLE = 3'b000,
    DCC_HDR = 3'b001,
    DCC_CODE = 3'b010,
    DCC_DEF = 3'b011,
    DCC_ADDR = 3'b100,
    DCC_DATA = 3'b101,
    DCC_SKIP = 3'b110
  } dcc_state_t;
endpackage

/* design/dcc_decode.sv */
/*
  Device-control common command decoder with bus drive selection.
  Assumes scl and sda come straight from pins; mode, address and
  error inputs come from logic on sys_clk.
*/
`timescale 1ns/1ps
module dcc_decode (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic sda_push_pull,
  input wire logic i3c_mode,
  input wire logic [6:0] own_address,
  input wire logic prev_xfer_error,
  output logic check_byte_enable,
  output logic parity_check_disable,
  output logic clear_all_events,
  output logic cmd_matched
);
  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

  // two flops per pin, then one delayed copy for edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ---------------------------------------------------------------
  // target match
  // ---------------------------------------------------------------
  function automatic logic target_hit(input logic [2:0] mask, input logic [6:0] field,
                                      input logic [6:0] own);
    logic hit;
    hit = 1'b0;
    case (mask)
      dcc_pkg::MASK_UNICAST: hit = (field == own); // RULE_01
      dcc_pkg::MASK_MULTICAST: hit = (field[6:dcc_pkg::ADDR_ID_LSB] == own[6:dcc_pkg::ADDR_ID_LSB]); // RULE_02
      dcc_pkg::MASK_BROADCAST: hit = 1'b1; // RULE_03
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // decoder state
  // ---------------------------------------------------------------
  dcc_pkg::dcc_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [6:0] shreg, next_shreg;
  logic repeated, next_repeated;
  logic [2:0] mask, next_mask;
  logic [1:0] first_sel, next_first_sel;
  logic [1:0] burst, next_burst;
  logic reg_format, next_reg_format;
  logic [2:0] data_idx, next_data_idx;
  logic ack_pend, next_ack_pend;
  logic ack_drv, next_ack_drv;
  logic check_en, next_check_en;
  logic parity_dis, next_parity_dis;
  logic clear_pulse, next_clear_pulse;
  logic matched, next_matched;
  logic push_pull, next_push_pull;

  logic [7:0] rx_byte;
  logic byte_done;
  logic [2:0] data_pos;
  logic is_data;
  assign rx_byte = {shreg, sda_s};
  assign byte_done = scl_rise && (bit_cnt == 4'h7);
  assign data_pos = {1'b0, first_sel} + data_idx; // RULE_04
  // bytes past the burst are the check byte when checking is on
  assign is_data = (data_pos < dcc_pkg::BYTE_LIMIT) && (!check_en || (data_idx <= {1'b0, burst})); // RULE_06

  // next-state computation for framing, fields and configuration
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_repeated = repeated;
    next_mask = mask;
    next_first_sel = first_sel;
    next_burst = burst;
    next_reg_format = reg_format;
    next_data_idx = data_idx;
    next_ack_pend = ack_pend;
    next_ack_drv = ack_drv;
    next_check_en = check_en;
    next_parity_dis = parity_dis;
    next_clear_pulse = 1'b0;
    next_matched = matched;
    if (bus_stop) begin
      next_state = dcc_pkg::DCC_IDLE;
      next_ack_drv = 1'b0;
      next_ack_pend = 1'b0;
      next_matched = 1'b0;
    end else if (bus_start) begin
      next_state = dcc_pkg::DCC_HDR;
      next_repeated = (state != dcc_pkg::DCC_IDLE);
      next_bit_cnt = 4'h0;
      next_ack_drv = 1'b0;
      next_ack_pend = 1'b0;
      next_matched = 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt == dcc_pkg::ACK_BIT) begin
        next_bit_cnt = 4'h0;
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
        next_shreg = rx_byte[6:0];
      end
      if (byte_done) begin
        case (state)
          dcc_pkg::DCC_HDR: begin
            if (rx_byte == dcc_pkg::HDR_WRITE && !(repeated && prev_xfer_error)) begin // RULE_12
              next_state = dcc_pkg::DCC_CODE;
              next_ack_pend = 1'b1;
            end else begin
              next_state = dcc_pkg::DCC_SKIP;
            end
          end
          dcc_pkg::DCC_CODE: begin
            next_state = (rx_byte == dcc_pkg::CODE_DEVICE_CONTROL) ? dcc_pkg::DCC_DEF : dcc_pkg::DCC_SKIP;
          end
          dcc_pkg::DCC_DEF: begin
            next_mask = rx_byte[dcc_pkg::DEF_MASK_LSB +: 3];
            next_first_sel = rx_byte[dcc_pkg::DEF_FIRST_LSB +: 2];
            next_burst = rx_byte[dcc_pkg::DEF_BURST_LSB +: 2];
            next_reg_format = rx_byte[dcc_pkg::DEF_FORMAT_BIT];
            next_state = dcc_pkg::DCC_ADDR;
          end
          dcc_pkg::DCC_ADDR: begin
            next_data_idx = 3'h0;
            next_matched = target_hit(mask, rx_byte[7:1], own_address);
            // register-write format is not decoded here
            if (target_hit(mask, rx_byte[7:1], own_address) && !reg_format) begin // RULE_07
              next_state = dcc_pkg::DCC_DATA;
            end else begin
              next_state = dcc_pkg::DCC_SKIP; // RULE_05
            end
          end
          dcc_pkg::DCC_DATA: begin
            next_data_idx = data_idx + 3'h1;
            if (is_data && data_pos == dcc_pkg::BYTE_CFG) begin
              next_check_en = rx_byte[dcc_pkg::B0_CHECK_EN_BIT]; // RULE_08
              next_parity_dis = rx_byte[dcc_pkg::B0_PARITY_DIS_BIT]; // RULE_09
            end
            if (is_data && data_pos == dcc_pkg::BYTE_INT) begin
              next_clear_pulse = rx_byte[dcc_pkg::B1_CLEAR_BIT]; // RULE_10
            end
            // other bits and bytes 2 and 3 are left alone, RULE_11
            if (!is_data) begin
              next_state = dcc_pkg::DCC_SKIP;
            end
          end
          default: next_state = state;
        endcase
      end
    end else if (scl_fall) begin
      // acknowledge window: drive after eighth bit, release after ninth
      if (ack_pend && bit_cnt == dcc_pkg::ACK_BIT) begin
        next_ack_drv = 1'b1; // RULE_15
        next_ack_pend = 1'b0;
      end else if (ack_drv && bit_cnt == 4'h0) begin
        next_ack_drv = 1'b0;
      end
    end
  end

  // drive mode: in i3c mode open-drain only for the plain-start header and acks, in i2c mode open-drain always
  always_comb begin
    next_push_pull = 1'b0; // RULE_13
    if (i3c_mode) begin
      next_push_pull = !((next_state == dcc_pkg::DCC_HDR && !next_repeated) || next_ack_drv); // RULE_14 RULE_16 RULE_17
    end
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dcc_pkg::DCC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 7'h00;
      repeated <= 1'b0;
      mask <= 3'h0;
      first_sel <= 2'h0;
      burst <= 2'h0;
      reg_format <= 1'b0;
      data_idx <= 3'h0;
      ack_pend <= 1'b0;
      ack_drv <= 1'b0;
      check_en <= dcc_pkg::RST_CHECK_EN;
      parity_dis <= dcc_pkg::RST_PARITY_DIS;
      clear_pulse <= 1'b0;
      matched <= 1'b0;
      push_pull <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      repeated <= next_repeated;
      mask <= next_mask;
      first_sel <= next_first_sel;
      burst <= next_burst;
      reg_format <= next_reg_format;
      data_idx <= next_data_idx;
      ack_pend <= next_ack_pend;
      ack_drv <= next_ack_drv;
      check_en <= next_check_en;
      parity_dis <= next_parity_dis;
      clear_pulse <= next_clear_pulse;
      matched <= next_matched;
      push_pull <= next_push_pull;
    end
  end

  // outputs straight from flops; the ack pulls low only
  assign sda_out = 1'b0;
  assign sda_oe = ack_drv;
  assign sda_push_pull = push_pull;
  assign check_byte_enable = check_en;
  assign parity_check_disable = parity_dis;
  assign clear_all_events = clear_pulse;
  assign cmd_matched = matched;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence hdr_taken_s;
    state == dcc_pkg::DCC_HDR && byte_done && rx_byte == dcc_pkg::HDR_WRITE;
  endsequence

  sequence ack_ready_s;
    ack_pend && scl_fall && bit_cnt == dcc_pkg::ACK_BIT && !bus_stop && !bus_start;
  endsequence

  AST_UNICAST_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
    state == dcc_pkg::DCC_ADDR && byte_done && mask == dcc_pkg::MASK_UNICAST && !bus_stop && !bus_start
    |=> matched == ($past(rx_byte[7:1]) == $past(own_address)))
    else $error("unicast match wrong");

  AST_MULTICAST_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
    state == dcc_pkg::DCC_ADDR && byte_done && mask == dcc_pkg::MASK_MULTICAST && !bus_stop && !bus_start
    |=> matched == ($past(rx_byte[7:4]) == $past(own_address[6:3])))
    else $error("multicast match wrong");

  AST_BROADCAST: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
    state == dcc_pkg::DCC_ADDR && byte_done && mask == dcc_pkg::MASK_BROADCAST && !bus_stop && !bus_start
    |=> matched)
    else $error("broadcast not taken");

  AST_FORMAT_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_07
    state == dcc_pkg::DCC_ADDR && byte_done && reg_format && !bus_stop && !bus_start
    |=> state == dcc_pkg::DCC_SKIP)
    else $error("register format entered data");

  AST_CHECK_EN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
    state == dcc_pkg::DCC_DATA && byte_done && is_data && data_pos == dcc_pkg::BYTE_CFG && !bus_stop && !bus_start
    |=> check_byte_enable == $past(rx_byte[7]) && parity_check_disable == $past(rx_byte[6]))
    else $error("config byte not applied");

  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
    clear_all_events |-> $past(state) == dcc_pkg::DCC_DATA && $past(data_pos) == dcc_pkg::BYTE_INT
    ##1 !clear_all_events)
    else $error("clear pulse bad");

  AST_NO_ACK_ERR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
    hdr_taken_s ##0 (repeated && prev_xfer_error && !bus_stop && !bus_start) |=> !ack_pend)
    else $error("ack after error");

  AST_ACK_OD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
    ack_ready_s |=> sda_oe ##1 !sda_push_pull)
    else $error("ack not open-drain");

  AST_I2C_OD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
    !i3c_mode ##1 !i3c_mode |-> !sda_push_pull)
    else $error("push-pull in i2c mode");

  AST_DATA_PP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_17
    i3c_mode && state == dcc_pkg::DCC_DATA && !ack_drv ##1 i3c_mode |-> sda_push_pull)
    else $error("data phase not push-pull");
endmodule

/* test/dcc_host_model.sv */
/*
  Host model for the two-wire bus: makes the bus clock, drives data open-drain.
  Assumes the bench resolves the data wire with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
module dcc_host_model (
  input wire logic sys_clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ---------------------------------------------------------------
  // idle and timing
  // ---------------------------------------------------------------
  // idle bus: clock stands high, data released
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // quarter of a 160 ns bus clock, stepping just after sys_clk rise
  task automatic q(input int n);
    repeat (2 * n) @(posedge sys_clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // bus conditions and bytes
  // ---------------------------------------------------------------
  // plain start from idle, open-drain
  task automatic start_cond();
    sda_low = 1'h1;
    q(2);
    scl = 1'h0;
    q(1);
  endtask
  // repeated start, entered with clock low
  task automatic rstart_cond();
    sda_low = 1'h0;
    q(1);
    scl = 1'h1;
    q(1);
    sda_low = 1'h1;
    q(1);
    scl = 1'h0;
    q(1);
  endtask
  // stop, entered with clock low
  task automatic stop_cond();
    sda_low = 1'h1;
    q(1);
    scl = 1'h1;
    q(1);
    sda_low = 1'h0;
    q(2);
  endtask
  // one bit, data held over the whole clock high
  task automatic put_bit(input logic v, output logic seen);
    sda_low = ~v;
    q(1);
    scl = 1'h1;
    q(1);
    seen = sda_line;
    q(1);
    scl = 1'h0;
    q(1);
  endtask
  // msb first, then release for ack or send odd parity as ninth bit
  task automatic send_byte(input logic [7:0] b, input logic rel, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], seen);
    end
    put_bit(rel | ~^b, seen);
    ack = ~seen;
  endtask
endmodule

/* test/tb_top.sv */
/*
  Self-checking bench for the device-control command decoder.
  Assumes the host model drives the bus and the data wire has a pull-up.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst_n, i3c_mode, prev_xfer_error, scl, sda_low, sda_line, sda_out, sda_oe, sda_push_pull;
  logic check_byte_enable, parity_check_disable, clear_all_events, cmd_matched, ack;
  logic [6:0] own_address;
  logic [8:0] pp_hist;
  int fails = 0;
  int checks = 0;
  int pulses = 0;
  // wired-and data line with pull-up
  assign sda_line = ~sda_low & ((sda_oe === 1'h1) ? sda_out : 1'h1);
  dcc_decode i_dcc_decode (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .sda_push_pull(sda_push_pull), .i3c_mode(i3c_mode), .own_address(own_address),
    .prev_xfer_error(prev_xfer_error), .check_byte_enable(check_byte_enable),
    .parity_check_disable(parity_check_disable), .clear_all_events(clear_all_events), .cmd_matched(cmd_matched));
  dcc_host_model i_dcc_host_model (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  // ---------------------------------------------------------------
  // clock and monitors
  // ---------------------------------------------------------------
  initial sys_clk = 1'h0;
  always #10 sys_clk = ~sys_clk;
  // drive mode seen in the middle of each bus clock high
  always @(posedge scl) begin
    repeat (2) @(negedge sys_clk);
    pp_hist <= {pp_hist[7:0], sda_push_pull};
  end
  // count event clear pulses
  always @(negedge sys_clk) begin
    if (clear_all_events === 1'h1) pulses <= pulses + 1;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one command up to its last data byte, no stop
  task automatic frame(input logic rs, input logic exp_ack, input logic [7:0] def, input logic [7:0] addr,
                       input int n, input logic [39:0] data, input logic exp_m);
    if (rs) i_dcc_host_model.rstart_cond();
    else i_dcc_host_model.start_cond();
    i_dcc_host_model.send_byte(dcc_pkg::HDR_WRITE, 1'h1, ack);
    check("header ack", ack, exp_ack);
    check("header drive", pp_hist, (rs && i3c_mode) ? {8'hff, ~exp_ack} : 9'h000);
    if (ack !== 1'h1) return;
    i_dcc_host_model.send_byte(dcc_pkg::CODE_DEVICE_CONTROL, 1'h0, ack);
    check("code drive", pp_hist, i3c_mode ? 9'h1ff : 9'h000);
    i_dcc_host_model.send_byte(def, 1'h0, ack);
    i_dcc_host_model.send_byte(addr, 1'h0, ack);
    for (int k = 0; k < n; k++) begin
      i_dcc_host_model.send_byte(data[39 - 8 * k -: 8], 1'h0, ack);
    end
    check("data drive", pp_hist, i3c_mode ? 9'h1ff : 9'h000);
    check("matched", cmd_matched, exp_m);
  endtask
  // whole command with stop, then configuration and pulse count
  task automatic run(input logic [7:0] def, input logic [7:0] addr, input int n, input logic [39:0] data,
                     input logic exp_m, input logic exp_cbe, input logic exp_pd, input logic [1:0] exp_p);
    int p0;
    p0 = pulses;
    frame(1'h0, 1'h1, def, addr, n, data, exp_m);
    i_dcc_host_model.stop_cond();
    repeat (4) @(posedge sys_clk);
    #1;
    check("check enable", check_byte_enable, exp_cbe);
    check("parity disable", parity_check_disable, exp_pd);
    check("clear pulses", 9'(pulses - p0), exp_p);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("reset", {sda_oe, sda_push_pull, check_byte_enable, parity_check_disable, clear_all_events,
      cmd_matched}, 9'h000);
  endtask
  task automatic t_broadcast();
    // burst of two: byte 1 stays data once checking turns on mid-command
    run(8'he2, 8'h00, 2, 40'hc0_08_00_00_00, 1'h1, 1'h1, 1'h1, 2'h1);
    run(8'he0, 8'h55, 2, 40'h3f_f7_00_00_00, 1'h1, 1'h0, 1'h0, 2'h0);
  endtask
  task automatic t_unicast();
    run(8'h00, {own_address, 1'h0}, 1, 40'h80_00_00_00_00, 1'h1, 1'h1, 1'h0, 2'h0);
    run(8'h00, {own_address ^ 7'h01, 1'h0}, 2, 40'h40_08_00_00_00, 1'h0, 1'h1, 1'h0, 2'h0);
  endtask
  task automatic t_multicast();
    run(8'h60, {own_address[6:3], 3'h4, 1'h0}, 1, 40'h40_00_00_00_00, 1'h1, 1'h0, 1'h1, 2'h0);
    run(8'h60, {~own_address[6], own_address[5:0], 1'h0}, 1, 40'hc0_00_00_00_00, 1'h0, 1'h0, 1'h1, 2'h0);
  endtask
  task automatic t_first_sel();
    run(8'he8, 8'h00, 1, 40'h08_00_00_00_00, 1'h1, 1'h0, 1'h1, 2'h1);
    run(8'hf0, 8'h00, 3, 40'hc0_c0_c0_00_00, 1'h1, 1'h0, 1'h1, 2'h0);
    run(8'hf8, 8'h00, 2, 40'h80_08_00_00_00, 1'h1, 1'h0, 1'h1, 2'h0);
  endtask
  task automatic t_format();
    run(8'he9, 8'h00, 2, 40'h08_c0_00_00_00, 1'h1, 1'h0, 1'h1, 2'h0);
  endtask
  task automatic t_burst();
    run(8'he0, 8'h00, 1, 40'h80_00_00_00_00, 1'h1, 1'h1, 1'h0, 2'h0);
    for (int b = 0; b < 4; b++) begin
      run(8'he0 | 8'(b << 1), 8'h00, b + 2, 40'h80_08_08_08_08, 1'h1, 1'h1, 1'h0, (b > 0) ? 2'h1 : 2'h0);
    end
  endtask
  task automatic t_repeat();
    prev_xfer_error = 1'h1;
    run(8'he0, 8'h00, 1, 40'h00_00_00_00_00, 1'h1, 1'h0, 1'h0, 2'h0);
    // transfer left open, so the next start counts as repeated
    frame(1'h0, 1'h1, 8'he0, 8'h00, 1, 40'h00_00_00_00_00, 1'h1);
    frame(1'h1, 1'h0, 8'he0, 8'h00, 1, 40'hc0_00_00_00_00, 1'h0);
    prev_xfer_error = 1'h0;
    frame(1'h1, 1'h1, 8'he0, 8'h00, 1, 40'hc0_00_00_00_00, 1'h1);
    i_dcc_host_model.stop_cond();
    repeat (4) @(posedge sys_clk);
    #1;
    check("after repeated start", {check_byte_enable, parity_check_disable}, 9'h003);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    i3c_mode = 1'h0;
    prev_xfer_error = 1'h0;
    own_address = 7'h4b;
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    t_broadcast();
    i3c_mode = 1'h1;
    t_unicast();
    t_multicast();
    t_first_sel();
    t_format();
    t_burst();
    t_repeat();
    final_report();
  end
  // cut a hang short
  initial begin
    #1000000;
    fails++;
    final_report();
  end
endmodule
